// File: tb/tuner_far_side.sv
// far side stand-in: series capacitor board and tuner control board lines
// assumes the bench sets the series home flag, tune request and match report
module tuner_far_side
(
	input wire logic i_limit_pair_n,
	input wire logic i_series_home,
	input wire logic i_tune_n,
	input wire logic i_match,
	output logic o_force_inhibit_n,
	output logic o_match_good_high
);
	timeunit 1ns;
	timeprecision 1ns;
	// forcing off home would fight the series step, so hold it off
	assign o_force_inhibit_n = i_limit_pair_n || i_series_home;
	assign o_match_good_high = !i_tune_n || i_match;
endmodule

// File: tb/tuner_servo_control_logic_bench.sv
// bench for the tuner servo logic: hand-written scenarios with state compares
// assumes the far-side model and the checker are compiled with it
module tuner_servo_control_logic_bench
	import tuner_servo_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clock = 0, i_resetn = 0, tn = 1, imn = 1, cmn = 1, home = 1, mt = 0;
	logic [3:0] err = 4'h0;
	logic inh_n, mgh, pos_n, pair_n, step_n, ch, ih, fl;
	servo_cmd_t srv;
	int miscompares = 0, cmp_count = 0, cycles = 0;
	wire logic [9:0] st = {pos_n, pair_n, step_n, srv, ch, ih, fl};
	always #10 i_clock = ~i_clock;
	tuner_far_side u_far (.i_limit_pair_n(pair_n), .i_series_home(home), .i_tune_n(tn),
		.i_match(mt), .o_force_inhibit_n(inh_n), .o_match_good_high(mgh));
	tuner_servo_control_logic u_dut (.i_clock(i_clock), .i_resetn(i_resetn), .i_error(err),
		.i_limit({imn, cmn, tn, inh_n}), .i_match_good_high(mgh), .o_pos_high_detect_n(pos_n),
		.o_limit_pair_n(pair_n), .o_series_step_n(step_n), .o_servo(srv),
		.o_capacitor_homing_latch(ch), .o_inductor_homing_latch(ih), .o_inductor_forcing_latch(fl));
	task automatic go(input int n);
		repeat (n) @(posedge i_clock);
		#2;
	endtask
	task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] s);
		cmp_count++;
		if (e !== s)
		begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	// limit inputs need the synchroniser delay, so settle generously
	task automatic look(input string nm, input logic [9:0] e);
		go(6);
		chk(nm, e, st);
	endtask
	task automatic error_drives;
		err = 4'h8;
		go(2);
		chk("pos drive", 10'h008, {6'h00, srv});
		err = 4'h5;
		go(2);
		chk("neg low drive", 10'h006, {6'h00, srv});
		err = 4'h2;
		go(2);
		chk("high drive", 10'h001, {6'h00, srv});
		err = 4'h5;
		mt = 1;
		go(2);
		chk("match block", 10'h000, {6'h00, srv});
		mt = 0;
	endtask
	task automatic tune_walk;
		tn = 0;
		go(2);
		tn = 1;
		err = 4'h9;
		look("homing", 10'h3AE);
		cmn = 0;
		look("cap max", 10'h3CA);
		imn = 0;
		look("pair", 10'h2D1);
		err = 4'hA;
		home = 0;
		look("clear", 10'h0C8);
		err = 4'h0;
		look("inhibit", 10'h280);
		cmn = 1;
		look("step", 10'h300);
		tn = 0;
		go(3);
		tn = 1;
		look("retune", 10'h3A4);
	endtask
	task automatic end_of_test;
		if (miscompares == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge i_clock)
	begin
		cycles++;
		if (cycles > 1000)
		begin
			miscompares++;
			end_of_test;
		end
	end
	initial
	begin
		go(2);
		i_resetn = 1;
		go(1);
		chk("idle", 10'h380, st);
		error_drives;
		tune_walk;
		end_of_test;
	end
endmodule

// File: tb/tuner_servo_sva.sv
// checker for latch, detector and drive gating relations
// assumes bind onto the top module ports, one clock domain
module tuner_servo_sva
	import tuner_servo_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_resetn,
	input wire error_sign_t i_error,
	input wire limit_in_t i_limit,
	input wire logic i_match_good_high,
	input wire logic o_pos_high_detect_n,
	input wire logic o_limit_pair_n,
	input wire logic o_series_step_n,
	input wire servo_cmd_t o_servo,
	input wire logic o_capacitor_homing_latch,
	input wire logic o_inductor_homing_latch,
	input wire logic o_inductor_forcing_latch
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_resetn);
	// three samples cover the two synchroniser stages plus the register
	sequence cmax3; !i_limit.cap_max_n [*3]; endsequence
	sequence lmin3; !i_limit.ind_min_n [*3]; endsequence
	chk_detect_sets: assert property (i_error.phase_pos && i_error.amp_high
		|=> !o_pos_high_detect_n) else $error("detect missing");
	chk_detect_clears: assert property (!o_pos_high_detect_n
		|-> !(o_capacitor_homing_latch || o_inductor_homing_latch || o_inductor_forcing_latch))
		else $error("latch survives detect");
	chk_pair_out: assert property (lmin3 and cmax3 |=> !o_limit_pair_n)
		else $error("limit pair missing");
	chk_cmax_stops: assert property (cmax3
		|=> !o_capacitor_homing_latch && o_series_step_n) else $error("cap max ignored");
	chk_lmin_stops: assert property (lmin3 |=> !o_inductor_homing_latch)
		else $error("ind min ignored");
	chk_latch_drives: assert property ((o_capacitor_homing_latch
		|=> o_servo.cap_increase)
		and (o_inductor_homing_latch |=> o_servo.ind_decrease)
		and (o_inductor_forcing_latch |=> o_servo.ind_increase))
		else $error("latch drive missing");
	chk_phase_block: assert property (i_match_good_high
		|| o_capacitor_homing_latch |=> !o_servo.cap_decrease) else $error("phase drive leaks");
	chk_amp_block: assert property (i_match_good_high && !o_inductor_homing_latch
		|=> !o_servo.ind_decrease) else $error("amp drive leaks");
	chk_step_cause: assert property (!o_series_step_n
		|-> !$past(o_capacitor_homing_latch) && !$past(i_error.phase_pos)
		&& !$past(i_error.phase_neg) && !$past(i_error.amp_low))
		else $error("step without cause");
endmodule
bind tuner_servo_control_logic tuner_servo_sva u_sva (.*);

// File: verilog/tuner_servo_control_logic.sv
// tuner servo control logic: homing and forcing latches, detectors and drive gating
// assumes error signs and the match-good-high line arrive synchronous to i_clock;
// limit, tune and inhibit lines are asynchronous and get synchronised here
//
// Operation
// RULE_01: phase positive and above 50 ohms detect
// RULE_02: active-low limit pair output to series board
// RULE_03: capacitor decrease on positive, increase on negative/home
// RULE_04: inductor increase below 50, decrease above
// RULE_05: series step on minimum, zero phase, not below
// RULE_06: series step suppressed at capacitor maximum
// RULE_07: capacitor homing suppresses zero-phase step detection
// RULE_08: positive-high detect clears all three latches
// RULE_09: latches cleared at power up
// RULE_10: tune pulse sets capacitor homing, drives increase
// RULE_11: capacitor maximum clears capacitor homing
// RULE_12: homing or tune blocks error phase drives
// RULE_13: tune pulse sets inductor homing, drives decrease
// RULE_14: inductor minimum clears inductor homing
// RULE_15: limit pair sets forcing, drives inductor increase
// RULE_16: series board inhibits forcing off home
// RULE_17: inhibit low keeps forcing latch from setting
// RULE_18: control board holds match-good-high during tune
// RULE_19: match-good-high blocks both phase drives
// RULE_20: control board signals match via both lines
// RULE_21: inductor latches or match-good-high block amplitude drives
// RULE_22: clocked latches, two-stage input synchronisers
// RULE_23: clear wins over set in latches
module tuner_servo_control_logic
	import tuner_servo_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_resetn,
	input wire error_sign_t i_error,
	input wire limit_in_t i_limit,
	input wire logic i_match_good_high,
	output logic o_pos_high_detect_n,
	output logic o_limit_pair_n,
	output logic o_series_step_n,
	output servo_cmd_t o_servo,
	output logic o_capacitor_homing_latch,
	output logic o_inductor_homing_latch,
	output logic o_inductor_forcing_latch
);
	// one synchroniser per asynchronous line; idle level is high
	logic [1:0] sync_ind_min_r;
	logic [1:0] sync_cap_max_r;
	logic [1:0] sync_tune_r;
	logic [1:0] sync_inhibit_r;
	logic capacitor_homing_latch_r;
	logic capacitor_homing_latch_nxt;
	logic inductor_homing_latch_r;
	logic inductor_homing_latch_nxt;
	logic inductor_forcing_latch_r;
	logic inductor_forcing_latch_nxt;
	logic pos_high_detect_n_r;
	logic limit_pair_n_r;
	logic series_step_n_r;
	logic cap_decrease_r;
	logic cap_increase_r;
	logic ind_increase_r;
	logic ind_decrease_r;
	servo_cmd_t servo_nxt;

	// one synchroniser step: the pin enters stage 0, stage 0 moves on to stage 1
	function automatic logic [1:0] sync_step(input logic [1:0] stages, input logic pin_n);
		sync_step = {stages[0], pin_n};
	endfunction

	// one latch step; clear is looked at first, so it wins [RULE_23]
	function automatic logic latch_step(input logic held, input logic set_in,
		input logic clear_in);
		if (clear_in)
		begin
			latch_step = LATCH_RESET;
		end
		else
		begin
			latch_step = held | set_in;
		end
	endfunction

	wire ind_min = ~sync_ind_min_r[1];
	wire cap_max = ~sync_cap_max_r[1];
	wire tune = ~sync_tune_r[1];
	wire inhibit = ~sync_inhibit_r[1];

	// first stage feeds only the second [RULE_22]
	always_ff @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			sync_ind_min_r <= SYNC_RESET;
		end
		else
		begin
			sync_ind_min_r <= sync_step(sync_ind_min_r, i_limit.ind_min_n);
		end
	end

	always_ff @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			sync_cap_max_r <= SYNC_RESET;
		end
		else
		begin
			sync_cap_max_r <= sync_step(sync_cap_max_r, i_limit.cap_max_n);
		end
	end

	always_ff @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			sync_tune_r <= SYNC_RESET;
		end
		else
		begin
			sync_tune_r <= sync_step(sync_tune_r, i_limit.tune_n);
		end
	end

	always_ff @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			sync_inhibit_r <= SYNC_RESET;
		end
		else
		begin
			sync_inhibit_r <= sync_step(sync_inhibit_r, i_limit.force_inhibit_n);
		end
	end

	// detectors
	wire pos_high = i_error.phase_pos & i_error.amp_high; // [RULE_01]
	wire limit_pair = ind_min & cap_max; // [RULE_02]
	// zero phase is hidden while the capacitor homes [RULE_07]
	wire zero_phase = ~i_error.phase_pos & ~i_error.phase_neg & ~capacitor_homing_latch_r;
	// step needs inductor minimum, zero phase, amplitude not low [RULE_05]
	wire series_step = ind_min & zero_phase & ~i_error.amp_low & ~cap_max; // [RULE_06]

	// latch next values: clear beats set [RULE_23] [RULE_08]
	wire cap_home_clr = pos_high | cap_max; // [RULE_11]
	wire ind_home_clr = pos_high | ind_min; // [RULE_14]
	wire ind_force_set = limit_pair & ~inhibit; // [RULE_15] [RULE_17]
	assign capacitor_homing_latch_nxt = latch_step(capacitor_homing_latch_r, tune,
		cap_home_clr); // [RULE_10]
	assign inductor_homing_latch_nxt = latch_step(inductor_homing_latch_r, tune,
		ind_home_clr); // [RULE_13]
	assign inductor_forcing_latch_nxt = latch_step(inductor_forcing_latch_r, ind_force_set,
		pos_high); // [RULE_15]

	// drive gating: home or tune shorts the phase error drives [RULE_12]
	wire phase_block = capacitor_homing_latch_r | tune | i_match_good_high; // [RULE_19]
	wire amp_block = inductor_homing_latch_r | inductor_forcing_latch_r
		| i_match_good_high; // [RULE_21]
	// match-good-high is raised by the control board through the tune pulse,
	// so the tune term above is kept as a local guard as well [RULE_18]
	assign servo_nxt.cap_decrease = i_error.phase_pos & ~phase_block; // [RULE_03]
	assign servo_nxt.cap_increase = (i_error.phase_neg & ~phase_block)
		| capacitor_homing_latch_r; // [RULE_03] [RULE_10]
	assign servo_nxt.ind_increase = (i_error.amp_low & ~amp_block)
		| inductor_forcing_latch_r; // [RULE_04] [RULE_15]
	assign servo_nxt.ind_decrease = (i_error.amp_high & ~amp_block)
		| inductor_homing_latch_r; // [RULE_04] [RULE_13]

	// latches are flip-flops: a tune pulse shorter than a clock can be missed
	// power-up leaves every latch cleared [RULE_09]
	always_ff @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			capacitor_homing_latch_r <= LATCH_RESET;
		end
		else
		begin
			capacitor_homing_latch_r <= capacitor_homing_latch_nxt; // [RULE_22]
		end
	end

	always_ff @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			inductor_homing_latch_r <= LATCH_RESET;
		end
		else
		begin
			inductor_homing_latch_r <= inductor_homing_latch_nxt;
		end
	end

	always_ff @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			inductor_forcing_latch_r <= LATCH_RESET;
		end
		else
		begin
			inductor_forcing_latch_r <= inductor_forcing_latch_nxt;
		end
	end

	// registered outputs; one cycle of latency buys glitch-free drive lines
	always_ff @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			pos_high_detect_n_r <= OUT_IDLE_N;
		end
		else
		begin
			pos_high_detect_n_r <= ~pos_high; // [RULE_01]
		end
	end

	always_ff @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			limit_pair_n_r <= OUT_IDLE_N;
		end
		else
		begin
			limit_pair_n_r <= ~limit_pair; // [RULE_02]
		end
	end

	always_ff @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			series_step_n_r <= OUT_IDLE_N;
		end
		else
		begin
			series_step_n_r <= ~series_step; // [RULE_05]
		end
	end

	always_ff @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			cap_decrease_r <= DRIVE_IDLE;
		end
		else
		begin
			cap_decrease_r <= servo_nxt.cap_decrease; // [RULE_03]
		end
	end

	always_ff @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			cap_increase_r <= DRIVE_IDLE;
		end
		else
		begin
			cap_increase_r <= servo_nxt.cap_increase; // [RULE_03]
		end
	end

	always_ff @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			ind_increase_r <= DRIVE_IDLE;
		end
		else
		begin
			ind_increase_r <= servo_nxt.ind_increase; // [RULE_04]
		end
	end

	always_ff @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			ind_decrease_r <= DRIVE_IDLE;
		end
		else
		begin
			ind_decrease_r <= servo_nxt.ind_decrease; // [RULE_04]
		end
	end

	assign o_pos_high_detect_n = pos_high_detect_n_r;
	assign o_limit_pair_n = limit_pair_n_r;
	assign o_series_step_n = series_step_n_r;
	assign o_servo = servo_cmd_t'({cap_decrease_r, cap_increase_r,
		ind_increase_r, ind_decrease_r});
	assign o_capacitor_homing_latch = capacitor_homing_latch_r;
	assign o_inductor_homing_latch = inductor_homing_latch_r;
	assign o_inductor_forcing_latch = inductor_forcing_latch_r;
endmodule

// File: verilog/tuner_servo_pkg.sv
// constants and carrier types for the tuner servo control logic
// assumes one 50 MHz clock and an active-low asynchronous reset
package tuner_servo_pkg;
	localparam int SYNC_STAGES = 2;
	localparam logic [1:0] SYNC_RESET = 2'h3;
	localparam logic LATCH_RESET = 1'h0;
	localparam logic OUT_IDLE_N = 1'h1;
	localparam logic DRIVE_IDLE = 1'h0;

	// error signs from the preamplifier level changers, active high
	typedef struct packed {
		logic phase_pos;
		logic phase_neg;
		logic amp_high;
		logic amp_low;
	} error_sign_t;

	// asynchronous limit and control lines, all active low
	typedef struct packed {
		logic ind_min_n;
		logic cap_max_n;
		logic tune_n;
		logic force_inhibit_n;
	} limit_in_t;

	// servo commands, active high
	typedef struct packed {
		logic cap_decrease;
		logic cap_increase;
		logic ind_increase;
		logic ind_decrease;
	} servo_cmd_t;
endpackage
